// ---- pkg/ppfm_pkg.sv ----
// Purpose: constants and types for the port pin function mux of ports 3 to 8
// Assumes: direction bit 1 = input, 0 = output; pins are synchronous to core_clk
package ppfm_pkg;
	localparam int P3_W = 7;
	localparam int P4_W = 8;
	localparam int P5_W = 8;
	localparam int P6_W = 4;
	localparam int P7_W = 6;
	localparam int P8_W = 1;
	localparam int P3_OD_W = 4;
	localparam int P3_PU_W = 3;
	localparam int CAP_N = 4;
	// port 3 pin positions
	localparam int P3_SER0 = 4;
	localparam int P3_SER1 = 5;
	localparam int P3_SER2 = 6;
	// port 6 pin positions
	localparam int P6_RD = 0;
	localparam int P6_WR = 1;
	localparam int P6_WAIT = 2;
	localparam int P6_ADDR_LATCH_STROBE = 3;
	// port 7 pin positions
	localparam int P7_T16A = 0;
	localparam int P7_T16A_CAP = 1;
	localparam int P7_T8A = 2;
	localparam int P7_T8B = 3;
	localparam int P7_PCL = 4;
	localparam int P7_T16B = 5;
	// capture edge slots
	localparam int CAP_T16A = 0;
	localparam int CAP_T16A_2ND = 1;
	localparam int CAP_T16B_2ND = 2;
	localparam int CAP_T16B = 3;
	// reset values
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] PU_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;

	typedef enum logic [1:0] {
		PPFM_EDGE_FALL = 2'b00,
		PPFM_EDGE_RISE = 2'b01,
		PPFM_EDGE_BOTH = 2'b10,
		PPFM_EDGE_NONE = 2'b11
	} ppfm_edge_t;

	typedef enum logic {
		PPFM_P3_CLOCKED = 1'b0,
		PPFM_P3_ASYNC = 1'b1
	} ppfm_p3_sel_t;

	typedef struct packed {
		logic [P3_W-1:0] port3_direction_reg;
		logic [P3_PU_W-1:0] port3_pullup_option;
		logic [P3_W-1:0] p3_latch;
		logic [P3_PU_W-1:0] p3_ctrl;
		ppfm_p3_sel_t p3_sel;
		logic [P4_W-1:0] port4_direction_reg;
		logic [P4_W-1:0] port4_pullup_option;
		logic [P4_W-1:0] p4_latch;
		logic [P5_W-1:0] port5_direction_reg;
		logic [P5_W-1:0] port5_pullup_option;
		logic [P5_W-1:0] p5_latch;
		logic [P6_W-1:0] port6_direction_reg;
		logic [P6_W-1:0] port6_pullup_option;
		logic [P6_W-1:0] p6_latch;
		logic mem_exp;
		logic wait_en;
		logic [P7_W-1:0] port7_direction_reg;
		logic [P7_W-1:0] port7_pullup_option;
		logic [P7_W-1:0] p7_latch;
		logic [P7_W-1:0] p7_ctrl;
		logic p7_buz_sel;
		ppfm_edge_t [CAP_N-1:0] cap_edge;
		logic port8_direction_reg;
		logic port8_pullup_option;
		logic p8_latch;
		logic p8_ctrl;
	} ppfm_cfg_t;

	typedef struct packed {
		logic [7:0] ad_out;
		logic ad_drive;
		logic [7:0] addr_hi;
		logic rd_n;
		logic wr_n;
		logic addr_latch_strobe;
	} ppfm_membus_t;

	typedef struct packed {
		logic csb_data_out;
		logic csb_sck_out;
		logic csb_sck_drive;
		logic asb_transmit_out;
	} ppfm_ser_src_t;

	typedef struct packed {
		logic tmr16a_out;
		logic tmr16b_out;
		logic tmr8a_out;
		logic tmr8b_out;
		logic clock_out_pin;
		logic buzzer_out_pin;
	} ppfm_tmr_src_t;
endpackage : ppfm_pkg

// ---- rtl/ppfm_edge_det.sv ----
// Purpose: per-bit edge detector with selectable valid edge, one-cycle pulse out
// Assumes: din is synchronous to core_clk
// Notes: no pulse on the first cycle after reset
`timescale 1ns/100ps
module ppfm_edge_det #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	input wire logic [2*W-1:0] sel,
	output logic [W-1:0] pulse
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] pulse;
		logic primed;
	} ppfm_edge_st_t;

	ppfm_edge_st_t st;
	ppfm_edge_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.prev = din;
		next_st.primed = 1'b1;
		for (int i = 0; i < W; i++) begin
			case (sel[2*i +: 2])
				ppfm_pkg::PPFM_EDGE_FALL: next_st.pulse[i] = st.primed & st.prev[i] & ~din[i];
				ppfm_pkg::PPFM_EDGE_RISE: next_st.pulse[i] = st.primed & ~st.prev[i] & din[i];
				ppfm_pkg::PPFM_EDGE_BOTH: next_st.pulse[i] = st.primed & (st.prev[i] ^ din[i]);
				default: next_st.pulse[i] = 1'b0;
			endcase
		end
		if (rst) begin
			next_st = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	assign pulse = st.pulse;
endmodule : ppfm_edge_det

// ---- rtl/ppfm_port_mux.sv ----
// Purpose: pin function mux for ports 3 to 8: GPIO, serial, memory bus, timers
// Assumes: all pin inputs synchronous to core_clk; oe_n low means the pin is driven
// Notes: all outputs registered; pins follow peripherals one cycle later
`timescale 1ns/100ps
module ppfm_port_mux (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sys_reset_n,
	input wire logic cfg_load,
	input ppfm_pkg::ppfm_cfg_t cfg_in,
	output ppfm_pkg::ppfm_cfg_t cfg_q,
	input wire logic key_flag_clr,
	input ppfm_pkg::ppfm_ser_src_t ser_src,
	input ppfm_pkg::ppfm_membus_t mem_bus,
	input ppfm_pkg::ppfm_tmr_src_t tmr_src,
	input wire logic [ppfm_pkg::P3_W-1:0] p3_pin_in,
	output logic [ppfm_pkg::P3_W-1:0] p3_pin_out,
	output logic [ppfm_pkg::P3_W-1:0] p3_pin_oe_n,
	output logic [ppfm_pkg::P3_W-1:0] p3_pullup_en,
	output logic [ppfm_pkg::P3_W-1:0] p3_read,
	input wire logic [ppfm_pkg::P4_W-1:0] p4_pin_in,
	output logic [ppfm_pkg::P4_W-1:0] p4_pin_out,
	output logic [ppfm_pkg::P4_W-1:0] p4_pin_oe_n,
	output logic [ppfm_pkg::P4_W-1:0] p4_pullup_en,
	output logic [ppfm_pkg::P4_W-1:0] p4_read,
	input wire logic [ppfm_pkg::P5_W-1:0] p5_pin_in,
	output logic [ppfm_pkg::P5_W-1:0] p5_pin_out,
	output logic [ppfm_pkg::P5_W-1:0] p5_pin_oe_n,
	output logic [ppfm_pkg::P5_W-1:0] p5_pullup_en,
	output logic [ppfm_pkg::P5_W-1:0] p5_read,
	input wire logic [ppfm_pkg::P6_W-1:0] p6_pin_in,
	output logic [ppfm_pkg::P6_W-1:0] p6_pin_out,
	output logic [ppfm_pkg::P6_W-1:0] p6_pin_oe_n,
	output logic [ppfm_pkg::P6_W-1:0] p6_pullup_en,
	output logic [ppfm_pkg::P6_W-1:0] p6_read,
	input wire logic [ppfm_pkg::P7_W-1:0] p7_pin_in,
	output logic [ppfm_pkg::P7_W-1:0] p7_pin_out,
	output logic [ppfm_pkg::P7_W-1:0] p7_pin_oe_n,
	output logic [ppfm_pkg::P7_W-1:0] p7_pullup_en,
	output logic [ppfm_pkg::P7_W-1:0] p7_read,
	input wire logic p8_pin_in,
	output logic p8_pin_out,
	output logic p8_pin_oe_n,
	output logic p8_pullup_en,
	output logic p8_read,
	output logic csb_data_in,
	output logic csb_serial_clock,
	output logic asb_receive_in,
	output logic asb_baud_clock_in,
	output logic csa_chip_select_n,
	output logic [7:0] mem_ad_in,
	output logic mem_wait_req,
	output logic key_return_req_flag,
	output logic key_return_interrupt,
	output logic tmr16a_count_capture_in,
	output logic tmr16b_count_capture_in,
	output logic tmr16a_capture_in,
	output logic tmr16b_capture_in,
	output logic tmr8a_count_in,
	output logic tmr8b_count_in,
	output logic tmr16a_capture_first_trig,
	output logic tmr16a_capture_second_trig,
	output logic tmr16b_capture_first_trig,
	output logic tmr16b_capture_second_trig
);
	typedef struct packed {
		ppfm_pkg::ppfm_cfg_t cfg;
		logic [ppfm_pkg::P3_W-1:0] p3_out;
		logic [ppfm_pkg::P3_W-1:0] p3_oe_n;
		logic [ppfm_pkg::P3_W-1:0] p3_pu;
		logic [ppfm_pkg::P3_W-1:0] p3_rd;
		logic [ppfm_pkg::P4_W-1:0] p4_out;
		logic [ppfm_pkg::P4_W-1:0] p4_oe_n;
		logic [ppfm_pkg::P4_W-1:0] p4_pu;
		logic [ppfm_pkg::P4_W-1:0] p4_rd;
		logic [ppfm_pkg::P5_W-1:0] p5_out;
		logic [ppfm_pkg::P5_W-1:0] p5_oe_n;
		logic [ppfm_pkg::P5_W-1:0] p5_pu;
		logic [ppfm_pkg::P5_W-1:0] p5_rd;
		logic [ppfm_pkg::P6_W-1:0] p6_out;
		logic [ppfm_pkg::P6_W-1:0] p6_oe_n;
		logic [ppfm_pkg::P6_W-1:0] p6_pu;
		logic [ppfm_pkg::P6_W-1:0] p6_rd;
		logic [ppfm_pkg::P7_W-1:0] p7_out;
		logic [ppfm_pkg::P7_W-1:0] p7_oe_n;
		logic [ppfm_pkg::P7_W-1:0] p7_pu;
		logic [ppfm_pkg::P7_W-1:0] p7_rd;
		logic p8_out;
		logic p8_oe_n;
		logic p8_pu;
		logic p8_rd;
		logic csb_di;
		logic csb_sck;
		logic asb_rx;
		logic asb_bclk;
		logic csa_cs_n;
		logic [7:0] ad_in;
		logic wait_req;
		logic key_flag;
		logic key_irq;
		logic t16a_in;
		logic t16b_in;
		logic t16a_cap;
		logic t16b_cap;
		logic t8a_in;
		logic t8b_in;
		logic t16a_first;
		logic t16a_second;
		logic t16b_first;
		logic t16b_second;
	} ppfm_mux_st_t;

	ppfm_mux_st_t st;
	ppfm_mux_st_t next_st;
	logic rst;
	logic [ppfm_pkg::P4_W-1:0] p4_fall;
	logic [ppfm_pkg::CAP_N-1:0] cap_pulse;
	logic [ppfm_pkg::CAP_N-1:0] cap_level;
	logic p3_clk_mode;

	// either reset source holds the whole block
	assign rst = srst | ~sys_reset_n;
	assign p3_clk_mode = (st.cfg.p3_sel == ppfm_pkg::PPFM_P3_CLOCKED);
	assign cap_level = {p7_pin_in[ppfm_pkg::P7_T16B], p7_pin_in[ppfm_pkg::P7_PCL],
		p7_pin_in[ppfm_pkg::P7_T16A_CAP], p7_pin_in[ppfm_pkg::P7_T16A]};

	// falling edges on port 4
	ppfm_edge_det #(.W(ppfm_pkg::P4_W)) u_key_edge (
		.core_clk(core_clk),
		.rst(rst),
		.din(p4_pin_in),
		.sel({ppfm_pkg::P4_W{ppfm_pkg::PPFM_EDGE_FALL}}),
		.pulse(p4_fall)
	);

	// capture trigger edges, live in port mode too
	ppfm_edge_det #(.W(ppfm_pkg::CAP_N)) u_cap_edge (
		.core_clk(core_clk),
		.rst(rst),
		.din(cap_level),
		.sel(st.cfg.cap_edge),
		.pulse(cap_pulse)
	);

	always_comb begin
		next_st = st;
		if (cfg_load) begin
			next_st.cfg = cfg_in;
		end
		// port 3 open-drain half: drive low only
		for (int i = 0; i < ppfm_pkg::P3_OD_W; i++) begin
			next_st.p3_out[i] = 1'b0;
			next_st.p3_oe_n[i] = st.cfg.port3_direction_reg[i] | st.cfg.p3_latch[i];
		end
		// port 3 push-pull half
		for (int i = ppfm_pkg::P3_OD_W; i < ppfm_pkg::P3_W; i++) begin
			next_st.p3_out[i] = st.cfg.p3_latch[i];
			next_st.p3_oe_n[i] = st.cfg.port3_direction_reg[i];
		end
		if (st.cfg.p3_ctrl[0]) begin
			next_st.p3_out[ppfm_pkg::P3_SER0] = ser_src.asb_transmit_out;
			next_st.p3_oe_n[ppfm_pkg::P3_SER0] = p3_clk_mode;
		end
		if (st.cfg.p3_ctrl[1]) begin
			next_st.p3_out[ppfm_pkg::P3_SER1] = ser_src.csb_data_out;
			next_st.p3_oe_n[ppfm_pkg::P3_SER1] = ~p3_clk_mode;
		end
		if (st.cfg.p3_ctrl[2]) begin
			next_st.p3_out[ppfm_pkg::P3_SER2] = ser_src.csb_sck_out;
			next_st.p3_oe_n[ppfm_pkg::P3_SER2] = ~(p3_clk_mode & ser_src.csb_sck_drive);
		end
		next_st.p3_pu = {st.cfg.port3_pullup_option & next_st.p3_oe_n[ppfm_pkg::P3_W-1:
			ppfm_pkg::P3_OD_W], {ppfm_pkg::P3_OD_W{1'b0}}};
		next_st.p3_rd = p3_pin_in;
		next_st.csb_di = (st.cfg.p3_ctrl[0] & p3_clk_mode) ? p3_pin_in[ppfm_pkg::P3_SER0] : 1'b1;
		next_st.asb_rx = (st.cfg.p3_ctrl[1] & ~p3_clk_mode) ? p3_pin_in[ppfm_pkg::P3_SER1] : 1'b1;
		next_st.csb_sck = (st.cfg.p3_ctrl[2] & p3_clk_mode) ? p3_pin_in[ppfm_pkg::P3_SER2] : 1'b1;
		next_st.asb_bclk = (st.cfg.p3_ctrl[2] & ~p3_clk_mode) ? p3_pin_in[ppfm_pkg::P3_SER2] : 1'b0;

		// port 4: GPIO or low address/data bus
		if (st.cfg.mem_exp) begin
			next_st.p4_out = mem_bus.ad_out;
			next_st.p4_oe_n = {ppfm_pkg::P4_W{~mem_bus.ad_drive}};
		end else begin
			next_st.p4_out = st.cfg.p4_latch;
			next_st.p4_oe_n = st.cfg.port4_direction_reg;
		end
		next_st.p4_pu = st.cfg.port4_pullup_option & next_st.p4_oe_n;
		next_st.p4_rd = p4_pin_in;
		next_st.ad_in = p4_pin_in;
		// set wins over a clear in the same cycle
		if (key_flag_clr) begin
			next_st.key_flag = 1'b0;
		end
		if (|p4_fall) begin
			next_st.key_flag = 1'b1;
		end
		next_st.key_irq = |p4_fall;

		// port 5: GPIO or high address byte
		if (st.cfg.mem_exp) begin
			next_st.p5_out = mem_bus.addr_hi;
			next_st.p5_oe_n = '0;
		end else begin
			next_st.p5_out = st.cfg.p5_latch;
			next_st.p5_oe_n = st.cfg.port5_direction_reg;
		end
		next_st.p5_pu = st.cfg.port5_pullup_option & next_st.p5_oe_n;
		next_st.p5_rd = p5_pin_in;

		// port 6: GPIO or bus strobes and wait
		next_st.p6_out = st.cfg.p6_latch;
		next_st.p6_oe_n = st.cfg.port6_direction_reg;
		next_st.wait_req = 1'b0;
		if (st.cfg.mem_exp) begin
			next_st.p6_out[ppfm_pkg::P6_RD] = mem_bus.rd_n;
			next_st.p6_out[ppfm_pkg::P6_WR] = mem_bus.wr_n;
			next_st.p6_out[ppfm_pkg::P6_ADDR_LATCH_STROBE] = mem_bus.addr_latch_strobe;
			next_st.p6_oe_n[ppfm_pkg::P6_RD] = 1'b0;
			next_st.p6_oe_n[ppfm_pkg::P6_WR] = 1'b0;
			next_st.p6_oe_n[ppfm_pkg::P6_ADDR_LATCH_STROBE] = 1'b0;
			if (st.cfg.wait_en) begin
				next_st.p6_oe_n[ppfm_pkg::P6_WAIT] = 1'b1;
				next_st.wait_req = ~p6_pin_in[ppfm_pkg::P6_WAIT];
			end
		end
		// without wait_en the wait pin keeps its GPIO setting above
		next_st.p6_pu = st.cfg.port6_pullup_option & next_st.p6_oe_n;
		next_st.p6_rd = p6_pin_in;

		// port 7: GPIO or timer, clock and buzzer pins
		next_st.p7_out = st.cfg.p7_latch;
		next_st.p7_oe_n = st.cfg.port7_direction_reg;
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_T16A]) begin
			next_st.p7_out[ppfm_pkg::P7_T16A] = tmr_src.tmr16a_out;
		end
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_T16A_CAP]) begin
			next_st.p7_oe_n[ppfm_pkg::P7_T16A_CAP] = 1'b1;
		end
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_T8A]) begin
			next_st.p7_out[ppfm_pkg::P7_T8A] = tmr_src.tmr8a_out;
		end
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_T8B]) begin
			next_st.p7_out[ppfm_pkg::P7_T8B] = tmr_src.tmr8b_out;
		end
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_PCL]) begin
			next_st.p7_out[ppfm_pkg::P7_PCL] = tmr_src.clock_out_pin;
		end
		if (st.cfg.p7_ctrl[ppfm_pkg::P7_T16B]) begin
			next_st.p7_out[ppfm_pkg::P7_T16B] = st.cfg.p7_buz_sel ? tmr_src.buzzer_out_pin :
				tmr_src.tmr16b_out;
		end
		next_st.p7_pu = st.cfg.port7_pullup_option & next_st.p7_oe_n;
		next_st.p7_rd = p7_pin_in;
		// input levels toward the timers
		next_st.t16a_in = p7_pin_in[ppfm_pkg::P7_T16A];
		next_st.t16a_cap = p7_pin_in[ppfm_pkg::P7_T16A_CAP];
		next_st.t8a_in = p7_pin_in[ppfm_pkg::P7_T8A];
		next_st.t8b_in = p7_pin_in[ppfm_pkg::P7_T8B];
		next_st.t16b_cap = p7_pin_in[ppfm_pkg::P7_PCL];
		next_st.t16b_in = p7_pin_in[ppfm_pkg::P7_T16B];
		// primary input triggers both, secondary only the first
		next_st.t16a_first = cap_pulse[ppfm_pkg::CAP_T16A] |
			cap_pulse[ppfm_pkg::CAP_T16A_2ND];
		next_st.t16a_second = cap_pulse[ppfm_pkg::CAP_T16A];
		next_st.t16b_first = cap_pulse[ppfm_pkg::CAP_T16B] |
			cap_pulse[ppfm_pkg::CAP_T16B_2ND];
		next_st.t16b_second = cap_pulse[ppfm_pkg::CAP_T16B];

		// port 8: GPIO or chip select input
		next_st.p8_out = st.cfg.p8_latch;
		next_st.p8_oe_n = st.cfg.port8_direction_reg | st.cfg.p8_ctrl;
		next_st.p8_pu = st.cfg.port8_pullup_option & next_st.p8_oe_n;
		next_st.p8_rd = p8_pin_in;
		next_st.csa_cs_n = st.cfg.p8_ctrl ? p8_pin_in : 1'b1;

		if (rst) begin
			next_st = '0;
			next_st.cfg.port3_direction_reg = ppfm_pkg::DIR_RST[ppfm_pkg::P3_W-1:0];
			next_st.cfg.port3_pullup_option = ppfm_pkg::PU_RST[ppfm_pkg::P3_PU_W-1:0];
			next_st.cfg.p3_latch = ppfm_pkg::LATCH_RST[ppfm_pkg::P3_W-1:0];
			next_st.cfg.port4_direction_reg = ppfm_pkg::DIR_RST[ppfm_pkg::P4_W-1:0];
			next_st.cfg.port5_direction_reg = ppfm_pkg::DIR_RST[ppfm_pkg::P5_W-1:0];
			next_st.cfg.port6_direction_reg = ppfm_pkg::DIR_RST[ppfm_pkg::P6_W-1:0];
			next_st.cfg.port7_direction_reg = ppfm_pkg::DIR_RST[ppfm_pkg::P7_W-1:0];
			next_st.cfg.port8_direction_reg = ppfm_pkg::DIR_RST[0];
			next_st.cfg.cap_edge = {ppfm_pkg::CAP_N{ppfm_pkg::PPFM_EDGE_NONE}};
			next_st.p3_oe_n = '1;
			next_st.p4_oe_n = '1;
			next_st.p5_oe_n = '1;
			next_st.p6_oe_n = '1;
			next_st.p7_oe_n = '1;
			next_st.p8_oe_n = 1'b1;
			next_st.csb_di = 1'b1;
			next_st.csb_sck = 1'b1;
			next_st.asb_rx = 1'b1;
			next_st.csa_cs_n = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		st <= next_st;
	end

	assign cfg_q = st.cfg;
	assign p3_pin_out = st.p3_out;
	assign p3_pin_oe_n = st.p3_oe_n;
	assign p3_pullup_en = st.p3_pu;
	assign p3_read = st.p3_rd;
	assign p4_pin_out = st.p4_out;
	assign p4_pin_oe_n = st.p4_oe_n;
	assign p4_pullup_en = st.p4_pu;
	assign p4_read = st.p4_rd;
	assign p5_pin_out = st.p5_out;
	assign p5_pin_oe_n = st.p5_oe_n;
	assign p5_pullup_en = st.p5_pu;
	assign p5_read = st.p5_rd;
	assign p6_pin_out = st.p6_out;
	assign p6_pin_oe_n = st.p6_oe_n;
	assign p6_pullup_en = st.p6_pu;
	assign p6_read = st.p6_rd;
	assign p7_pin_out = st.p7_out;
	assign p7_pin_oe_n = st.p7_oe_n;
	assign p7_pullup_en = st.p7_pu;
	assign p7_read = st.p7_rd;
	assign p8_pin_out = st.p8_out;
	assign p8_pin_oe_n = st.p8_oe_n;
	assign p8_pullup_en = st.p8_pu;
	assign p8_read = st.p8_rd;
	assign csb_data_in = st.csb_di;
	assign csb_serial_clock = st.csb_sck;
	assign asb_receive_in = st.asb_rx;
	assign asb_baud_clock_in = st.asb_bclk;
	assign csa_chip_select_n = st.csa_cs_n;
	assign mem_ad_in = st.ad_in;
	assign mem_wait_req = st.wait_req;
	assign key_return_req_flag = st.key_flag;
	assign key_return_interrupt = st.key_irq;
	assign tmr16a_count_capture_in = st.t16a_in;
	assign tmr16b_count_capture_in = st.t16b_in;
	assign tmr16a_capture_in = st.t16a_cap;
	assign tmr16b_capture_in = st.t16b_cap;
	assign tmr8a_count_in = st.t8a_in;
	assign tmr8b_count_in = st.t8b_in;
	assign tmr16a_capture_first_trig = st.t16a_first;
	assign tmr16a_capture_second_trig = st.t16a_second;
	assign tmr16b_capture_first_trig = st.t16b_first;
	assign tmr16b_capture_second_trig = st.t16b_second;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_p3_open_drain: assert property (
		st.p3_out[3:0] == 4'h0 && (~st.p3_oe_n[3:0] & ~st.p3_pu[3:0]) == ~st.p3_oe_n[3:0]
	) else $error("open-drain pin drives high");

	chk_p3_pullup_gate: assert property (
		!$past(rst) |-> (st.p3_pu[6:4] & ~$past(st.cfg.port3_pullup_option)) == 3'h0
	) else $error("port 3 pull-up without option bit");

	chk_key_flag_set: assert property (
		(|p4_fall) |=> key_return_req_flag && key_return_interrupt
			##1 (key_return_req_flag || $past(key_flag_clr))
	) else $error("key-return flag not set by falling edge");

	chk_p4_bus_drive: assert property (
		$past(st.cfg.mem_exp) && !$past(rst) |-> p4_pin_out == $past(mem_bus.ad_out)
			&& p4_pin_oe_n == {8{~$past(mem_bus.ad_drive)}}
	) else $error("port 4 not on address/data bus");

	chk_p5_addr_out: assert property (
		$past(st.cfg.mem_exp) && !$past(rst) |-> p5_pin_out == $past(mem_bus.addr_hi)
			&& p5_pin_oe_n == 8'h00
	) else $error("port 5 not driving high address");

	chk_p6_wait_gpio: assert property (
		$past(st.cfg.mem_exp && !st.cfg.wait_en) && !$past(rst)
			|-> p6_pin_oe_n[ppfm_pkg::P6_WAIT] ==
			$past(st.cfg.port6_direction_reg[ppfm_pkg::P6_WAIT]) && !mem_wait_req
	) else $error("wait pin not left as GPIO");

	chk_async_baud_in: assert property (
		$past(st.cfg.p3_ctrl[2] && st.cfg.p3_sel == ppfm_pkg::PPFM_P3_ASYNC) && !$past(rst)
			|-> p3_pin_oe_n[ppfm_pkg::P3_SER2]
	) else $error("baud clock pin driven");

	chk_cap_second_only: assert property (
		cap_pulse[ppfm_pkg::CAP_T16A_2ND] && !cap_pulse[ppfm_pkg::CAP_T16A]
			|=> tmr16a_capture_first_trig && !tmr16a_capture_second_trig
	) else $error("secondary input hit second capture");

	chk_cs_input: assert property (
		$past(st.cfg.p8_ctrl) && !$past(rst) |-> p8_pin_oe_n && csa_chip_select_n == $past(p8_pin_in)
	) else $error("chip select pin not an input");
endmodule : ppfm_port_mux

// ---- verif/ppfm_pin_partner.sv ----
// Purpose: far-side pin model that drives a port pin when the block lets go of it and ext_en is high
// Assumes: ext_en high means the outside device drives ext_val onto the pin
// Notes: a line with no driver and no pull-up toggles every cycle
`timescale 1ns/100ps
module ppfm_pin_partner #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] pullup_en,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pin
);
	logic [W-1:0] flt = '0;
	always @(posedge core_clk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!oe_n[i]) pin[i] = pin_out[i];
			else if (ext_en[i]) pin[i] = ext_val[i];
			else if (pullup_en[i]) pin[i] = 1'b1;
			else pin[i] = flt[i];
		end
	end
endmodule : ppfm_pin_partner

// ---- verif/tb_ppfm_port_mux.sv ----
// Purpose: directed bench for the port pin function mux
// Assumes: inputs change on the falling edge of core_clk
// Notes: port 4 pins come from the partner model
`timescale 1ns/100ps
module tb_ppfm_port_mux;
	logic core_clk = 0, srst = 1, sys_reset_n = 0, cfg_load = 0, key_flag_clr = 0;
	ppfm_pkg::ppfm_cfg_t cfg_in = '0, cfg_q, c;
	ppfm_pkg::ppfm_ser_src_t ser_src = '0;
	ppfm_pkg::ppfm_membus_t mem_bus = '0;
	ppfm_pkg::ppfm_tmr_src_t tmr_src = '0;
	logic [6:0] p3_pin_in = '0, p3_pin_out, p3_pin_oe_n, p3_pullup_en, p3_read;
	logic [7:0] p4_pin_in, p4_pin_out, p4_pin_oe_n, p4_pullup_en, p4_read;
	logic [7:0] p5_pin_in = '0, p5_pin_out, p5_pin_oe_n, p5_pullup_en, p5_read;
	logic [7:0] mem_ad_in, p4_ext_en = 8'hFF, p4_ext_val = 8'hFF;
	logic [3:0] p6_pin_in = 4'hF, p6_pin_out, p6_pin_oe_n, p6_pullup_en, p6_read;
	logic [5:0] p7_pin_in = 6'h01, p7_pin_out, p7_pin_oe_n, p7_pullup_en, p7_read;
	logic p8_pin_in = 0, p8_pin_out, p8_pin_oe_n, p8_pullup_en, p8_read;
	logic csb_data_in, csb_serial_clock, asb_receive_in, asb_baud_clock_in;
	logic csa_chip_select_n, mem_wait_req, key_return_req_flag, key_return_interrupt;
	logic tmr16a_count_capture_in, tmr16b_count_capture_in, tmr16a_capture_in;
	logic tmr16b_capture_in, tmr8a_count_in, tmr8b_count_in;
	logic tmr16a_capture_first_trig, tmr16a_capture_second_trig;
	logic tmr16b_capture_first_trig, tmr16b_capture_second_trig;
	int err_count = 0, n_tests = 0, cyc = 0;
	ppfm_port_mux u_ppfm_port_mux (.*);
	ppfm_pin_partner #(.W(8)) u_ppfm_pin_partner (.core_clk(core_clk), .pin_out(p4_pin_out),
		.oe_n(p4_pin_oe_n), .pullup_en(p4_pullup_en), .ext_en(p4_ext_en),
		.ext_val(p4_ext_val), .pin(p4_pin_in));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task automatic ld(input ppfm_pkg::ppfm_cfg_t v);
		cfg_in = v;
		cfg_load = 1;
		tick(1);
		cfg_load = 0;
		tick(1);
	endtask : ld
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		tick(8);
		srst = 0;
		sys_reset_n = 1;
		chk("p4 dir", 8'hFF, cfg_q.port4_direction_reg);
		chk("p4 oe_n", 8'hFF, p4_pin_oe_n);
		chk("cs_n", 8'h01, 8'(csa_chip_select_n));
		c = '0;
		c.cap_edge = '1;
		c.port3_direction_reg = 7'h7C;
		c.p3_latch = 7'h02;
		c.port3_pullup_option = 3'h1;
		c.port4_direction_reg = 8'hFF;
		c.port4_pullup_option = 8'h0F;
		c.p5_latch = 8'hA5;
		c.port6_direction_reg = 4'hF;
		c.port7_direction_reg = 6'h3F;
		c.port8_direction_reg = 1'b1;
		ld(c);
		chk("p5 out", 8'hA5, p5_pin_out);
		chk("p5 oe_n", 8'h00, p5_pin_oe_n);
		chk("p3 od oe_n", 8'h02, 8'(p3_pin_oe_n[1:0]));
		chk("p3 od out", 8'h00, 8'(p3_pin_out[1:0]));
		chk("p3 pullup", 8'h10, 8'(p3_pullup_en));
		chk("p4 pullup", 8'h0F, p4_pullup_en);
		key_flag_clr = 1;
		tick(1);
		key_flag_clr = 0;
		chk("key flag", 8'h00, 8'(key_return_req_flag));
		p4_ext_val = 8'h7F;
		tick(1);
		chk("key early", 8'h00, 8'(key_return_req_flag));
		tick(1);
		chk("key set", 8'h03, 8'({key_return_req_flag, key_return_interrupt}));
		tick(1);
		chk("key hold", 8'h02, 8'({key_return_req_flag, key_return_interrupt}));
		c.mem_exp = 1;
		c.wait_en = 1;
		p6_pin_in = 4'h0;
		mem_bus = '{ad_out: 8'h96, ad_drive: 1, addr_hi: 8'h3C, rd_n: 0, wr_n: 1, addr_latch_strobe: 1};
		ld(c);
		chk("ad out", 8'h96, p4_pin_out);
		chk("ad oe_n", 8'h00, p4_pin_oe_n);
		chk("a hi", 8'h3C, p5_pin_out);
		chk("strobes", 8'h0A, 8'(p6_pin_out & 4'hB));
		chk("p6 oe_n", 8'h04, 8'(p6_pin_oe_n));
		chk("wait", 8'h01, 8'(mem_wait_req));
		c.wait_en = 0;
		ld(c);
		chk("wait off", 8'h00, 8'(mem_wait_req));
		chk("ad in", 8'h96, mem_ad_in);
		chk("p4 read", 8'h96, p4_read);
		chk("p6 read", 8'h00, 8'(p6_read));
		c.mem_exp = 0;
		c.cap_edge[ppfm_pkg::CAP_T16A] = ppfm_pkg::PPFM_EDGE_FALL;
		c.cap_edge[ppfm_pkg::CAP_T16A_2ND] = ppfm_pkg::PPFM_EDGE_RISE;
		ld(c);
		p7_pin_in = 6'h00;
		tick(2);
		chk("cap a", 8'h03,
			8'({tmr16a_capture_first_trig, tmr16a_capture_second_trig}));
		p7_pin_in = 6'h02;
		tick(2);
		chk("cap a 2nd", 8'h02,
			8'({tmr16a_capture_first_trig, tmr16a_capture_second_trig}));
		c.p3_ctrl = 3'h7;
		c.p3_sel = ppfm_pkg::PPFM_P3_CLOCKED;
		ser_src = '{csb_data_out: 1, csb_sck_out: 0, csb_sck_drive: 1, asb_transmit_out: 0};
		p3_pin_in = 7'h10;
		ld(c);
		chk("csb oe_n", 8'h01, 8'(p3_pin_oe_n[6:4]));
		chk("csb out", 8'h02, 8'(p3_pin_out[6:4]));
		chk("csb in", 8'h0A,
			8'({csb_data_in, csb_serial_clock, asb_receive_in, asb_baud_clock_in}));
		chk("p3 read", 8'h10, 8'(p3_read));
		c.p3_sel = ppfm_pkg::PPFM_P3_ASYNC;
		c.p8_ctrl = 1'b1;
		c.port8_pullup_option = 1'b1;
		c.p7_ctrl = 6'h21;
		c.p7_buz_sel = 1'b1;
		c.port7_direction_reg = 6'h3E;
		c.cap_edge[ppfm_pkg::CAP_T16B] = ppfm_pkg::PPFM_EDGE_RISE;
		ser_src.asb_transmit_out = 1'b1;
		tmr_src = '{tmr16a_out: 1, tmr16b_out: 0, tmr8a_out: 0, tmr8b_out: 0,
			clock_out_pin: 0, buzzer_out_pin: 1};
		p3_pin_in = 7'h40;
		ld(c);
		chk("asb oe_n", 8'h06, 8'(p3_pin_oe_n[6:4]));
		chk("asb out", 8'h03, 8'(p3_pin_out[6:4]));
		chk("asb in", 8'h0D,
			8'({csb_data_in, csb_serial_clock, asb_receive_in, asb_baud_clock_in}));
		chk("cs sel", 8'h06,
			8'({p8_pin_oe_n, p8_pullup_en, csa_chip_select_n}));
		chk("tmr pins", 8'h21, 8'(p7_pin_out));
		chk("tmr oe_n", 8'h3E, 8'(p7_pin_oe_n));
		p7_pin_in = 6'h2A;
		tick(1);
		chk("tmr in", 8'h2A, 8'({tmr16b_count_capture_in, tmr16b_capture_in, tmr8b_count_in,
			tmr8a_count_in, tmr16a_capture_in, tmr16a_count_capture_in}));
		chk("p7 read", 8'h2A, 8'(p7_read));
		tick(1);
		chk("cap b", 8'h03,
			8'({tmr16b_capture_first_trig, tmr16b_capture_second_trig}));
		sys_reset_n = 0;
		tick(1);
		chk("rst dir", 8'hFF, cfg_q.port5_direction_reg);
		chk("rst oe_n", 8'hFF, p5_pin_oe_n);
		sys_reset_n = 1;
		close_out();
	end
endmodule : tb_ppfm_port_mux
